// >>> core/can_fifo_status_pkg.sv
// Package with register map, field layout and constants of the CAN FIFO status and filter block
package can_fifo_status_pkg;
    localparam int unsigned addr_width = 4;
    localparam logic [3:0] off_filter = 4'h0;
    localparam logic [3:0] off_fifo_flags = 4'h1;
    localparam logic [3:0] off_user_addr = 4'h2;
    localparam logic [3:0] off_msg_index = 4'h3;
    localparam logic [3:0] off_control = 4'h4;
    localparam logic [3:0] off_irq_status = 4'h5;
    localparam logic [3:0] off_irq_mask = 4'h6;
    localparam logic [3:0] off_base_addr = 4'h7;

    localparam int unsigned sid_hi = 31;
    localparam int unsigned sid_lo = 21;
    localparam int unsigned exide_bit = 19;
    localparam int unsigned eid_hi = 17;
    localparam int unsigned eid_lo = 0;
    localparam logic [31:0] filter_writable = 32'hffeb_ffff;

    localparam int unsigned tx_half_bit = 9;
    localparam int unsigned tx_empty_bit = 8;
    localparam int unsigned rx_ovfl_bit = 3;
    localparam int unsigned rx_full_bit = 2;
    localparam int unsigned rx_half_bit = 1;
    localparam int unsigned rx_nempty_bit = 0;

    localparam int unsigned ctl_filter_en_bit = 0;
    localparam int unsigned ctl_tx_dir_bit = 1;
    localparam int unsigned ctl_config_bit = 2;

    localparam int unsigned irq_ovfl_bit = 0;
    localparam int unsigned irq_match_bit = 1;
    localparam int unsigned irq_done_bit = 2;

    localparam int unsigned idx_width = 5;
    localparam logic [4:0] fifo_depth_m1 = 5'h1f;
    localparam logic [5:0] fifo_half = 6'h10;
    localparam logic [5:0] fifo_full = 6'h20;
    localparam logic [31:0] msg_bytes = 32'h0000_0010;
    localparam logic [31:0] reset_base = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef struct packed {
        logic valid;
        logic ext;
        logic [10:0] standard_identifier;
        logic [17:0] extended_identifier;
    } msg_id_type;

    typedef struct packed {
        logic [31:0] filter;
        logic filter_en;
        logic tx_dir;
        logic config_mode;
        logic [31:0] base;
        logic [4:0] head;
        logic [4:0] tail;
        logic [5:0] count;
        logic ovfl;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
        logic match;
    } state_type;
endpackage

// >>> core/can_id_match.sv
// Acceptance filter comparison of one message identifier against the filter word
`timescale 1ns/1ns
module can_id_match (
    input wire logic [31:0] i_filter,
    input wire can_fifo_status_pkg::msg_id_type i_msg,
    output logic o_match
);
    logic want_ext;
    logic sid_ok;
    logic eid_ok;
    always_comb begin
        want_ext = i_filter[can_fifo_status_pkg::exide_bit];
        sid_ok = (i_filter[can_fifo_status_pkg::sid_hi:can_fifo_status_pkg::sid_lo] == i_msg.standard_identifier);
        eid_ok = !want_ext || (i_filter[can_fifo_status_pkg::eid_hi:can_fifo_status_pkg::eid_lo] == i_msg.extended_identifier);
        o_match = i_msg.valid && (want_ext == i_msg.ext) && sid_ok && eid_ok;
    end
endmodule

// >>> core/can_fifo_status.sv
// CAN FIFO status flags, user address, message index and acceptance filter
`timescale 1ns/1ns
// Summary of operation
// - Each standard identifier filter bit must equal the message bit to pass.
// - Format select one accepts only extended messages, zero only standard.
// - With format select one, each extended identifier filter bit must equal the message bit.
// - Filter word is writable only while the filter is disabled.
// - Transmit half-empty flag is one when occupancy at most half.
// - Transmit empty flag is one when no message is queued.
// - Receive overflow flag set on overflow event, zero in transmit mode.
// - Receive full flag is one exactly while every slot holds a message.
// - Receive half-full flag is one when occupancy at least half.
// - Receive not-empty flag is one while a message is stored.
// - Flags of the unselected direction read zero.
// - Occupancy flags are read-only and track the FIFO state.
// - Transmit user address returns head, where software writes next message.
// - Receive user address returns tail, where software reads next message.
// - Two lowest user address bits always read zero.
// - Transmit message index reports slot to be sent next.
// - Receive message index reports slot for next stored message.
module can_fifo_status (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire can_fifo_status_pkg::msg_id_type i_msg,
    input wire logic i_can_done,
    input wire logic i_user_done,
    output logic o_accept,
    output logic [4:0] o_can_index,
    output logic o_irq
);
    can_fifo_status_pkg::state_type st_r;
    can_fifo_status_pkg::state_type st_nxt;
    can_fifo_status_pkg::bus_req_type req;
    logic hit;
    logic [31:0] flags;
    logic can_step;
    logic user_step;
    logic rx_ovfl_evt;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    can_id_match u_match (
        .i_filter(st_r.filter),
        .i_msg(i_msg),
        .o_match(hit)
    );

    function automatic logic [4:0] next_slot(input logic [4:0] idx);
        next_slot = (idx == can_fifo_status_pkg::fifo_depth_m1) ? 5'h00 : idx + 5'h01;
    endfunction

    function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [4:0] idx);
        logic [31:0] a;
        a = base + 32'({27'h0, idx}) * can_fifo_status_pkg::msg_bytes;
        slot_addr = {a[31:2], 2'h0};
    endfunction

    always_comb begin
        flags = 32'h0;
        if (st_r.tx_dir) begin
            flags[can_fifo_status_pkg::tx_half_bit] = (st_r.count <= can_fifo_status_pkg::fifo_half);
            flags[can_fifo_status_pkg::tx_empty_bit] = (st_r.count == 6'h00);
        end else begin
            flags[can_fifo_status_pkg::rx_ovfl_bit] = st_r.ovfl;
            flags[can_fifo_status_pkg::rx_full_bit] = (st_r.count == can_fifo_status_pkg::fifo_full);
            flags[can_fifo_status_pkg::rx_half_bit] = (st_r.count >= can_fifo_status_pkg::fifo_half);
            flags[can_fifo_status_pkg::rx_nempty_bit] = (st_r.count != 6'h00);
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 32'h0;
        st_nxt.match = 1'b0;
        rx_ovfl_evt = 1'b0;
        can_step = 1'b0;
        user_step = 1'b0;
        if (!st_r.config_mode) begin
            if (st_r.tx_dir) begin
                can_step = i_can_done && (st_r.count != 6'h00);
                user_step = i_user_done && (st_r.count != can_fifo_status_pkg::fifo_full);
            end else begin
                st_nxt.match = hit && st_r.filter_en;
                can_step = st_nxt.match && (st_r.count != can_fifo_status_pkg::fifo_full);
                rx_ovfl_evt = st_nxt.match && (st_r.count == can_fifo_status_pkg::fifo_full);
                user_step = i_user_done && (st_r.count != 6'h00);
            end
        end
        if (can_step) begin
            if (st_r.tx_dir) begin
                st_nxt.tail = next_slot(st_r.tail);
            end else begin
                st_nxt.head = next_slot(st_r.head);
            end
        end
        if (user_step) begin
            if (st_r.tx_dir) begin
                st_nxt.head = next_slot(st_r.head);
            end else begin
                st_nxt.tail = next_slot(st_r.tail);
            end
        end
        if (st_r.tx_dir) begin
            st_nxt.count = st_r.count + (user_step ? 6'h01 : 6'h00) - (can_step ? 6'h01 : 6'h00);
        end else begin
            st_nxt.count = st_r.count + (can_step ? 6'h01 : 6'h00) - (user_step ? 6'h01 : 6'h00);
        end
        if (req.wr) begin
            case (req.addr)
                can_fifo_status_pkg::off_filter: begin
                    if (!st_r.filter_en) begin
                        st_nxt.filter = req.wdata & can_fifo_status_pkg::filter_writable;
                    end
                end
                can_fifo_status_pkg::off_fifo_flags: begin
                    if (req.wdata[can_fifo_status_pkg::rx_ovfl_bit]) begin
                        st_nxt.ovfl = 1'b0;
                    end
                end
                can_fifo_status_pkg::off_control: begin
                    st_nxt.filter_en = req.wdata[can_fifo_status_pkg::ctl_filter_en_bit];
                    st_nxt.config_mode = req.wdata[can_fifo_status_pkg::ctl_config_bit];
                    if (req.wdata[can_fifo_status_pkg::ctl_config_bit]) begin
                        st_nxt.tx_dir = req.wdata[can_fifo_status_pkg::ctl_tx_dir_bit];
                        st_nxt.head = 5'h00;
                        st_nxt.tail = 5'h00;
                        st_nxt.count = 6'h00;
                        st_nxt.ovfl = 1'b0;
                    end
                end
                can_fifo_status_pkg::off_irq_status: begin
                    st_nxt.irq_status = st_r.irq_status & ~req.wdata[2:0];
                end
                can_fifo_status_pkg::off_irq_mask: begin
                    st_nxt.irq_mask = req.wdata[2:0];
                end
                can_fifo_status_pkg::off_base_addr: begin
                    if (st_r.config_mode) begin
                        st_nxt.base = req.wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        // Set wins over clear
        if (rx_ovfl_evt) begin
            st_nxt.ovfl = 1'b1;
            st_nxt.irq_status[can_fifo_status_pkg::irq_ovfl_bit] = 1'b1;
        end
        if (st_nxt.match) begin
            st_nxt.irq_status[can_fifo_status_pkg::irq_match_bit] = 1'b1;
        end
        if (can_step && st_r.tx_dir) begin
            st_nxt.irq_status[can_fifo_status_pkg::irq_done_bit] = 1'b1;
        end
        if (req.rd) begin
            case (req.addr)
                can_fifo_status_pkg::off_filter: st_nxt.rdata = st_r.filter;
                can_fifo_status_pkg::off_fifo_flags: st_nxt.rdata = flags;
                can_fifo_status_pkg::off_user_addr: begin
                    st_nxt.rdata = slot_addr(st_r.base, st_r.tx_dir ? st_r.head : st_r.tail);
                end
                can_fifo_status_pkg::off_msg_index: st_nxt.rdata = {27'h0, o_can_index};
                can_fifo_status_pkg::off_control: begin
                    st_nxt.rdata = {29'h0, st_r.config_mode, st_r.tx_dir, st_r.filter_en};
                end
                can_fifo_status_pkg::off_irq_status: st_nxt.rdata = {29'h0, st_r.irq_status};
                can_fifo_status_pkg::off_irq_mask: st_nxt.rdata = {29'h0, st_r.irq_mask};
                can_fifo_status_pkg::off_base_addr: st_nxt.rdata = st_r.base;
                default: st_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
            st_r.config_mode <= 1'b1;
            st_r.base <= can_fifo_status_pkg::reset_base;
        end else begin
            st_r <= st_nxt;
        end
    end

    // index of next send or store slot
    assign o_can_index = st_r.tx_dir ? st_r.tail : st_r.head;
    assign o_rdata = st_r.rdata;
    assign o_accept = st_r.match;
    assign o_irq = |(st_r.irq_status & st_r.irq_mask);

    property p_filter_locked;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_wr && i_addr == can_fifo_status_pkg::off_filter && st_r.filter_en) |=> $stable(st_r.filter);
    endproperty
    a_filter_locked: assert property (p_filter_locked) else $error("Filter changed while enabled");

    property p_tx_empty;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        st_r.tx_dir |-> (flags[8] == (st_r.count == 6'h00)) && (flags[3:0] == 4'h0);
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("Transmit empty flag wrong");

    property p_tx_half;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (st_r.tx_dir && st_r.count == 6'h11) |-> !flags[9];
    endproperty
    a_tx_half: assert property (p_tx_half) else $error("Half empty flag wrong above half");

    property p_rx_full;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !st_r.tx_dir |-> (flags[2] == (st_r.count == 6'h20)) && (flags[9:8] == 2'h0);
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("Receive full flag wrong");

    property p_rx_half;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (!st_r.tx_dir && st_r.count == 6'h0f) |-> !flags[1] && flags[0];
    endproperty
    a_rx_half: assert property (p_rx_half) else $error("Half full flag wrong below half");

    property p_ovfl_set;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        rx_ovfl_evt |=> st_r.ovfl && o_accept;
    endproperty
    a_ovfl_set: assert property (p_ovfl_set) else $error("Overflow not recorded");

    property p_ua_aligned;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rd && i_addr == can_fifo_status_pkg::off_user_addr) |=> o_rdata[1:0] == 2'h0;
    endproperty
    a_ua_aligned: assert property (p_ua_aligned) else $error("User address not aligned");

    property p_index_wrap;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (can_step && o_can_index == 5'h1f) |=> o_can_index == 5'h00;
    endproperty
    a_index_wrap: assert property (p_index_wrap) else $error("Message index did not wrap");

    property p_index_step;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (can_step && !(i_wr && i_addr == can_fifo_status_pkg::off_control))
            |=> o_can_index == $past(o_can_index) + 5'h01;
    endproperty
    a_index_step: assert property (p_index_step) else $error("Message index did not advance");

    c_rx_full: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) flags[2]);
    c_overflow: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) rx_ovfl_evt);
    c_tx_drain: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) st_r.tx_dir && can_step);
    c_rx_half: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) flags[1] && !flags[2]);
    c_tx_half: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) st_r.tx_dir && !flags[9]);

    logic ctl_wr;
    assign ctl_wr = req.wr && (req.addr == can_fifo_status_pkg::off_control);

    property p_rx_levels;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !st_r.tx_dir |-> (flags[0] == (st_r.count != 6'h00)) && (flags[1] == (st_r.count >= 6'h10));
    endproperty
    a_rx_levels: assert property (p_rx_levels) else $error("Receive level flags wrong");

    property p_flags_ro;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_wr && i_addr == can_fifo_status_pkg::off_fifo_flags && !i_wdata[3] && !can_step && !user_step
            && !rx_ovfl_evt) |=> $stable(st_r.count) && $stable(st_r.ovfl);
    endproperty
    a_flags_ro: assert property (p_flags_ro) else $error("Flag write changed FIFO state");

    property p_ovfl_clear;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_wr && i_addr == can_fifo_status_pkg::off_fifo_flags && i_wdata[3] && !rx_ovfl_evt) |=> !st_r.ovfl;
    endproperty
    a_ovfl_clear: assert property (p_ovfl_clear) else $error("Overflow not cleared");

    property p_filter_write;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_wr && i_addr == can_fifo_status_pkg::off_filter && !st_r.filter_en)
            |=> st_r.filter == ($past(i_wdata) & can_fifo_status_pkg::filter_writable);
    endproperty
    a_filter_write: assert property (p_filter_write) else $error("Filter write lost while disabled");

    property p_ext_mismatch;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_msg.valid && (i_msg.ext != st_r.filter[can_fifo_status_pkg::exide_bit])) |=> !o_accept;
    endproperty
    a_ext_mismatch: assert property (p_ext_mismatch) else $error("Wrong format accepted");

    property p_sid_mismatch;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_msg.valid && (i_msg.standard_identifier != st_r.filter[can_fifo_status_pkg::sid_hi:can_fifo_status_pkg::sid_lo]))
            |=> !o_accept;
    endproperty
    a_sid_mismatch: assert property (p_sid_mismatch) else $error("Standard bits mismatch accepted");

    property p_eid_mismatch;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_msg.valid && i_msg.ext
            && (i_msg.extended_identifier != st_r.filter[can_fifo_status_pkg::eid_hi:can_fifo_status_pkg::eid_lo])) |=> !o_accept;
    endproperty
    a_eid_mismatch: assert property (p_eid_mismatch) else $error("Extended bits mismatch accepted");

    property p_accept_gate;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (st_r.tx_dir || st_r.config_mode || !st_r.filter_en) |=> !o_accept;
    endproperty
    a_accept_gate: assert property (p_accept_gate) else $error("Accept outside receive operation");

    property p_rx_store;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (can_step && !user_step && !st_r.tx_dir && !ctl_wr) |=> st_r.count == $past(st_r.count) + 6'h01;
    endproperty
    a_rx_store: assert property (p_rx_store) else $error("Stored message not counted");

    property p_tx_send;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (can_step && !user_step && st_r.tx_dir && !ctl_wr) |=> st_r.count == $past(st_r.count) - 6'h01;
    endproperty
    a_tx_send: assert property (p_tx_send) else $error("Sent message not removed");

    property p_ua_head;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rd && i_addr == can_fifo_status_pkg::off_user_addr && st_r.tx_dir)
            |=> o_rdata[31:2] == 30'(($past(st_r.base) + {23'h0, $past(st_r.head), 4'h0}) >> 2);
    endproperty
    a_ua_head: assert property (p_ua_head) else $error("Transmit user address wrong");

    property p_ua_tail;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rd && i_addr == can_fifo_status_pkg::off_user_addr && !st_r.tx_dir)
            |=> o_rdata[31:2] == 30'(($past(st_r.base) + {23'h0, $past(st_r.tail), 4'h0}) >> 2);
    endproperty
    a_ua_tail: assert property (p_ua_tail) else $error("Receive user address wrong");
endmodule

// >>> verification/can_node_model.sv
// Far-side CAN node model: delivers identifiers and transmit completions
`timescale 1ns/1ns
module can_node_model (
    input wire logic i_core_clk,
    output can_fifo_status_pkg::msg_id_type o_msg,
    output logic o_can_done
);
    initial begin
        o_msg = '0;
        o_can_done = 1'b0;
    end
    // One received identifier, fields scrambled once released
    task automatic send_msg(input logic ext, input logic [10:0] standard_identifier, input logic [17:0] extended_identifier);
        @(posedge i_core_clk);
        o_msg <= {1'b1, ext, standard_identifier, extended_identifier};
        @(posedge i_core_clk);
        o_msg <= {1'b0, ~ext, ~standard_identifier, ~extended_identifier};
    endtask
    // One frame completed on the bus
    task automatic send_done();
        @(posedge i_core_clk);
        o_can_done <= 1'b1;
        @(posedge i_core_clk);
        o_can_done <= 1'b0;
    endtask
endmodule

// >>> verification/can_fifo_status_test.sv
// Self-checking bench for the CAN FIFO status and filter block
`timescale 1ns/1ns
module can_fifo_status_test;
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_user_done = 1'b0;
    logic [31:0] o_rdata;
    can_fifo_status_pkg::msg_id_type i_msg;
    logic i_can_done;
    logic o_accept;
    logic [4:0] o_can_index;
    logic o_irq;
    logic [31:0] lfsr = 32'ha0c6;
    logic [31:0] filt;
    logic [31:0] base = 32'h0000_1000;
    logic [31:0] rv;
    logic [2:0] irqs;
    logic [2:0] mask;
    logic txd, ovf, fen;
    int n_fail = 0;
    int num_checks = 0;
    int cnt, head, tail;
    always #2 i_core_clk = ~i_core_clk;
    can_fifo_status u_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_msg(i_msg), .i_can_done(i_can_done),
        .i_user_done(i_user_done), .o_accept(o_accept), .o_can_index(o_can_index), .o_irq(o_irq));
    can_node_model u_node (.i_core_clk(i_core_clk), .o_msg(i_msg), .o_can_done(i_can_done));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [31:0] flags();
        if (txd) return {22'h0, cnt <= 16, cnt == 0, 8'h0};
        return {28'h0, ovf, cnt == 32, cnt >= 16, cnt != 0};
    endfunction
    task automatic wrap_up();
        $display("Checks %0d, failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
        chk(rv, exp, what);
    endtask
    task automatic cfg(input logic c, input logic t, input logic e);
        wr(can_fifo_status_pkg::off_control, {29'h0, c, t, e});
        fen = e;
        if (c) begin
            txd = t;
            {cnt, head, tail, ovf} = '0;
        end
    endtask
    task automatic check_all();
        int ptr;
        ptr = txd ? head : tail;
        rchk(can_fifo_status_pkg::off_fifo_flags, flags(), "flags");
        chk(rv, flags(), "occupancy flags");
        rchk(can_fifo_status_pkg::off_user_addr, base + 32'(ptr * 16), "user address");
        chk({30'h0, rv[1:0]}, 32'h0, "address alignment");
        rchk(can_fifo_status_pkg::off_msg_index, 32'(txd ? tail : head), "index register");
        chk({27'h0, o_can_index}, 32'(txd ? tail : head), "index port");
        rchk(can_fifo_status_pkg::off_irq_status, {29'h0, irqs}, "irq status");
        chk({31'h0, o_irq}, {31'h0, |(irqs & mask)}, "irq line");
    endtask
    task automatic rx_msg(input logic ext, input logic [10:0] standard_identifier, input logic [17:0] extended_identifier);
        logic m;
        m = fen && !txd && ext == filt[19] && standard_identifier == filt[31:21] && (!ext || extended_identifier == filt[17:0]);
        u_node.send_msg(ext, standard_identifier, extended_identifier);
        #1;
        chk({31'h0, o_accept}, {31'h0, m}, "accept");
        if (m) begin
            irqs |= 3'h2;
            if (cnt == 32) begin
                ovf = 1'b1;
                irqs |= 3'h1;
            end else begin
                cnt++;
                head = (head + 1) % 32;
            end
        end
    endtask
    task automatic udone();
        @(posedge i_core_clk);
        i_user_done <= 1'b1;
        @(posedge i_core_clk);
        i_user_done <= 1'b0;
        if (txd && cnt < 32) begin
            cnt++;
            head = (head + 1) % 32;
        end else if (!txd && cnt > 0) begin
            cnt--;
            tail = (tail + 1) % 32;
        end
    endtask
    task automatic cdone();
        u_node.send_done();
        cnt--;
        tail = (tail + 1) % 32;
        irqs |= 3'h4;
    endtask
    initial begin
        repeat (100000) @(posedge i_core_clk);
        n_fail++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        wrap_up();
    end
    initial begin
        {txd, ovf, fen, irqs, cnt, head, tail} = '0;
        mask = 3'h7;
        repeat (16) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        cfg(1'b1, 1'b0, 1'b0);
        wr(can_fifo_status_pkg::off_base_addr, base);
        wr(can_fifo_status_pkg::off_irq_mask, {29'h0, mask});
        filt = nxt(lfsr) & can_fifo_status_pkg::filter_writable | 32'h0008_0000;
        wr(can_fifo_status_pkg::off_filter, filt);
        rchk(can_fifo_status_pkg::off_filter, filt, "filter write");
        // Filter is read only while enabled, base address is read only outside configuration
        cfg(1'b0, 1'b0, 1'b1);
        wr(can_fifo_status_pkg::off_filter, ~filt);
        rchk(can_fifo_status_pkg::off_filter, filt, "filter locked");
        @(posedge i_core_clk);
        #1;
        chk(o_rdata, 32'h0, "read data held one cycle");
        wr(can_fifo_status_pkg::off_base_addr, 32'h0000_5550);
        wr(4'hc, 32'hffff_ffff);
        rchk(4'hc, 32'h0, "unmapped");
        rchk(can_fifo_status_pkg::off_base_addr, base, "base locked");
        rchk(can_fifo_status_pkg::off_control, 32'h0000_0001, "control");
        rchk(can_fifo_status_pkg::off_irq_mask, {29'h0, mask}, "irq mask");
        check_all();
        for (int i = 0; i < 80; i++) begin
            lfsr = nxt(lfsr);
            if (i == 40) begin
                cfg(1'b0, 1'b0, 1'b0);
                rx_msg(filt[19], filt[31:21], filt[17:0]);
                filt = lfsr & can_fifo_status_pkg::filter_writable & 32'hfff7_ffff;
                wr(can_fifo_status_pkg::off_filter, filt);
                cfg(1'b0, 1'b0, 1'b1);
            end
            case (lfsr[2:0])
                3'h0: rx_msg(lfsr[31], lfsr[30:20], lfsr[17:0]);
                3'h1: rx_msg(~filt[19], filt[31:21], filt[17:0]);
                3'h2: rx_msg(filt[19], filt[31:21] ^ (11'h1 << (lfsr[7:4] % 11)), filt[17:0]);
                3'h3: rx_msg(filt[19], filt[31:21], filt[17:0] ^ (18'h1 << (lfsr[8:4] % 18)));
                default: rx_msg(filt[19], filt[31:21], filt[17:0]);
            endcase
            check_all();
        end
        wr(can_fifo_status_pkg::off_fifo_flags, 32'hffff_fff7);
        check_all();
        wr(can_fifo_status_pkg::off_fifo_flags, 32'h0000_0008);
        ovf = 1'b0;
        check_all();
        for (int i = 0; i < 34; i++) begin
            udone();
            check_all();
        end
        cfg(1'b1, 1'b1, 1'b1);
        cfg(1'b0, 1'b1, 1'b1);
        rx_msg(filt[19], filt[31:21], filt[17:0]);
        for (int i = 0; i < 70; i++) begin
            lfsr = nxt(lfsr);
            if (cnt > 0 && ((i < 40) ? lfsr[1:0] == 2'h0 : lfsr[1:0] != 2'h0)) cdone();
            else udone();
            check_all();
        end
        mask = 3'h0;
        wr(can_fifo_status_pkg::off_irq_mask, 32'h0);
        check_all();
        mask = 3'h7;
        wr(can_fifo_status_pkg::off_irq_mask, 32'h7);
        wr(can_fifo_status_pkg::off_irq_status, 32'h7);
        irqs = 3'h0;
        check_all();
        wrap_up();
    end
endmodule
